// ### rtl/gpf_pkg.sv
package gpf_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] GPF_OFF_F_DATA = 8'h60;
  localparam logic [7:0] GPF_OFF_G_DATA = 8'h61;
  localparam logic [7:0] GPF_OFF_H_DATA = 8'h62;
  localparam logic [7:0] GPF_OFF_F_DIR  = 8'h64;
  localparam logic [7:0] GPF_OFF_G_DIR  = 8'h65;
  localparam logic [7:0] GPF_OFF_H_DIR  = 8'h66;
  localparam logic [7:0] GPF_OFF_F_FSEL = 8'h68;
  localparam logic [7:0] GPF_OFF_G_FSEL = 8'h69;
  localparam logic [7:0] GPF_OFF_H_FSEL = 8'h6a;
  localparam logic [7:0] GPF_OFF_F_DRV  = 8'h6c;

  // ------------------------------------------------------------
  // Reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [7:0] GPF_RST_LATCH  = 8'hff;
  localparam logic [7:0] GPF_RST_DIR    = 8'h00;
  localparam logic [7:0] GPF_RST_FSEL   = 8'h00;
  localparam logic [7:0] GPF_RST_DRV    = 8'h00;
  localparam logic [7:0] GPF_MSK_H_FSEL = 8'h3f;
  localparam logic [7:0] GPF_MSK_F_DRV  = 8'h03;

  // ------------------------------------------------------------
  // Field positions in the three ports
  // ------------------------------------------------------------
  localparam int GPF_F_SER_LO  = 0;
  localparam int GPF_F_REQ2    = 3;
  localparam int GPF_F_ACK2    = 4;
  localparam int GPF_F_REQ3    = 5;
  localparam int GPF_F_ACK3    = 6;
  localparam int GPF_F_TBCLK   = 7;
  localparam int GPF_G_CMP_LO  = 4;
  localparam int GPF_H_CMP_NUM = 6;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpf_pin_drv_s;

  // Pin level for inputs, latch for outputs
  function automatic logic [7:0] gpf_readback(input logic [7:0] dir,
                                               input logic [7:0] latch,
                                               input logic [7:0] pin);
    gpf_readback = (dir & latch) | (~dir & pin);
  endfunction : gpf_readback

endpackage : gpf_pkg

// ### rtl/gpf_sync.sv
`timescale 1ns/10ps
module gpf_sync
  import gpf_pkg::*;
#(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  // Data
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule : gpf_sync

// ### rtl/gpf_pin_drive.sv
`timescale 1ns/10ps
module gpf_pin_drive
  import gpf_pkg::*;
(
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  // Port setup
  input  wire logic [7:0]   i_dir,
  input  wire logic [7:0]   i_fsel,
  input  wire logic [7:0]   i_odrain,
  input  wire logic [7:0]   i_latch,
  input  wire logic [7:0]   i_alt_out,
  // Pad drive
  output gpf_pin_drv_s      o_drv
);

  logic [7:0] src;

  // Peripheral takes the data path; direction still comes from the port
  assign src = (i_fsel & i_alt_out) | (~i_fsel & i_latch);

  // Open drain releases the pad on a one instead of driving it high
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_drv.out <= GPF_RST_LATCH;
      o_drv.oe  <= GPF_RST_DIR;
    end else begin
      o_drv.out <= src;
      o_drv.oe  <= i_dir & ~(i_odrain & src);
    end
  end

endmodule : gpf_pin_drive

// ### rtl/gpf_ports.sv
// Contract
// - First port: 8-bit GPIO, direction bit 0 input, 1 output.
// - Reset clears first port direction and function select.
// - Reset sets every data latch bit to one, pins input.
// - First port function bit 1 gives pin to peripheral, 0 keeps GPIO.
// - First port pins 0-2 carry the serial bus interface.
// - First port pins 3 and 5 are DMA requests for channels 2, 3.
// - First port pins 4 and 6 drive DMA acknowledges for channels 2, 3.
// - First port pin 7 feeds the time base external clock.
// - DMA signals go through the first port when both ports select them.
// - Drive type: pins 0,1 CMOS or open drain; other bits read 0.
// - Second port: 8-bit GPIO with its own direction register.
// - Reset clears second port direction and function select.
// - Second port pins 0-3 capture inputs, pins 4-7 compare outputs.
// - Second port function bit selects timer when 1, GPIO when 0.
// - Third port: 8-bit GPIO with its own direction register.
// - Third port pins 0-5 drive further compare outputs.
// - Reset clears third port direction and function select.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module gpf_ports
  import gpf_pkg::*;
(
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  // Register port
  input  wire logic [7:0]   i_addr,
  input  wire logic [7:0]   i_wr_data,
  input  wire logic         i_wr,
  input  wire logic         i_rd,
  output logic      [7:0]   o_rd_data,
  // Pads
  input  wire logic [7:0]   i_pf_pin,
  input  wire logic [7:0]   i_pg_pin,
  input  wire logic [7:0]   i_ph_pin,
  output gpf_pin_drv_s      o_pf_drv,
  output gpf_pin_drv_s      o_pg_drv,
  output gpf_pin_drv_s      o_ph_drv,
  // Serial bus interface
  input  wire logic [2:0]   i_serial_bus_interface_out,
  output logic      [2:0]   o_serial_bus_interface_in,
  // DMA unit and the shared other port
  input  wire logic         i_dma_acknowledge_ch2,
  input  wire logic         i_dma_acknowledge_ch3,
  input  wire logic [1:0]   i_alt_port_dma_sel,
  input  wire logic [1:0]   i_alt_port_dma_request,
  output logic              o_dma_request_ch2,
  output logic              o_dma_request_ch3,
  output logic [1:0]        o_alt_port_dma_acknowledge,
  // Timers
  input  wire logic [9:0]   i_compare_out,
  output logic [3:0]        o_capture_trigger_in,
  output logic              o_time_base_ext_clock_in
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] pf_latch_reg;
  logic [7:0] pg_latch_reg;
  logic [7:0] ph_latch_reg;
  logic [7:0] pf_dir_reg;
  logic [7:0] pg_dir_reg;
  logic [7:0] ph_dir_reg;
  logic [7:0] pf_fsel_reg;
  logic [7:0] pg_fsel_reg;
  logic [7:0] ph_fsel_reg;
  logic [7:0] pf_drv_reg;
  logic [7:0] rd_next;
  logic [7:0] pf_pin_s;
  logic [7:0] pg_pin_s;
  logic [7:0] ph_pin_s;
  logic [7:0] pf_alt;
  logic [7:0] pg_alt;
  logic [7:0] ph_alt;

  function automatic logic hit(input logic [7:0] off);
    hit = i_wr && (i_addr == off);
  endfunction : hit

  // ------------------------------------------------------------
  // Pad input synchronisers
  // ------------------------------------------------------------
  gpf_sync #(
    .WIDTH (24)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_async   ({i_ph_pin, i_pg_pin, i_pf_pin}),
    .o_sync    ({ph_pin_s, pg_pin_s, pf_pin_s})
  );

  // ------------------------------------------------------------
  // Data latches
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pf_latch_reg <= GPF_RST_LATCH;
      pg_latch_reg <= GPF_RST_LATCH;
      ph_latch_reg <= GPF_RST_LATCH;
    end else begin
      if (hit(GPF_OFF_F_DATA)) begin
        pf_latch_reg <= i_wr_data;
      end
      if (hit(GPF_OFF_G_DATA)) begin
        pg_latch_reg <= i_wr_data;
      end
      if (hit(GPF_OFF_H_DATA)) begin
        ph_latch_reg <= i_wr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Direction registers
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pf_dir_reg <= GPF_RST_DIR;
      pg_dir_reg <= GPF_RST_DIR;
      ph_dir_reg <= GPF_RST_DIR;
    end else begin
      if (hit(GPF_OFF_F_DIR)) begin
        pf_dir_reg <= i_wr_data;
      end
      if (hit(GPF_OFF_G_DIR)) begin
        pg_dir_reg <= i_wr_data;
      end
      if (hit(GPF_OFF_H_DIR)) begin
        ph_dir_reg <= i_wr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Function select and drive type
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pf_fsel_reg <= GPF_RST_FSEL;
      pg_fsel_reg <= GPF_RST_FSEL;
      ph_fsel_reg <= GPF_RST_FSEL;
      pf_drv_reg  <= GPF_RST_DRV;
    end else begin
      if (hit(GPF_OFF_F_FSEL)) begin
        pf_fsel_reg <= i_wr_data;
      end
      if (hit(GPF_OFF_G_FSEL)) begin
        pg_fsel_reg <= i_wr_data;
      end
      // Top two bits have no function behind them
      if (hit(GPF_OFF_H_FSEL)) begin
        ph_fsel_reg <= i_wr_data & GPF_MSK_H_FSEL;
      end
      if (hit(GPF_OFF_F_DRV)) begin
        pf_drv_reg <= i_wr_data & GPF_MSK_F_DRV;
      end
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    case (i_addr)
      GPF_OFF_F_DATA: rd_next = gpf_readback(pf_dir_reg, pf_latch_reg, pf_pin_s);
      GPF_OFF_G_DATA: rd_next = gpf_readback(pg_dir_reg, pg_latch_reg, pg_pin_s);
      GPF_OFF_H_DATA: rd_next = gpf_readback(ph_dir_reg, ph_latch_reg, ph_pin_s);
      GPF_OFF_F_DIR:  rd_next = pf_dir_reg;
      GPF_OFF_G_DIR:  rd_next = pg_dir_reg;
      GPF_OFF_H_DIR:  rd_next = ph_dir_reg;
      GPF_OFF_F_FSEL: rd_next = pf_fsel_reg;
      GPF_OFF_G_FSEL: rd_next = pg_fsel_reg;
      GPF_OFF_H_FSEL: rd_next = ph_fsel_reg;
      GPF_OFF_F_DRV:  rd_next = pf_drv_reg;
      default:        rd_next = 8'h00;
    endcase
  end

  // Data stand for the one cycle after the strobe only
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd ? rd_next : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // Pad drive
  // ------------------------------------------------------------
  assign pf_alt = {1'b0, i_dma_acknowledge_ch3, 1'b0, i_dma_acknowledge_ch2,
                   1'b0, i_serial_bus_interface_out};
  assign pg_alt = {i_compare_out[3:0], 4'h0};
  assign ph_alt = {2'b00, i_compare_out[9:4]};

  gpf_pin_drive u_pf_drive (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_dir     (pf_dir_reg),
    .i_fsel    (pf_fsel_reg),
    .i_odrain  (pf_drv_reg),
    .i_latch   (pf_latch_reg),
    .i_alt_out (pf_alt),
    .o_drv     (o_pf_drv)
  );

  gpf_pin_drive u_pg_drive (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_dir     (pg_dir_reg),
    .i_fsel    (pg_fsel_reg),
    .i_odrain  (8'h00),
    .i_latch   (pg_latch_reg),
    .i_alt_out (pg_alt),
    .o_drv     (o_pg_drv)
  );

  gpf_pin_drive u_ph_drive (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_dir     (ph_dir_reg),
    .i_fsel    (ph_fsel_reg),
    .i_odrain  (8'h00),
    .i_latch   (ph_latch_reg),
    .i_alt_out (ph_alt),
    .o_drv     (o_ph_drv)
  );

  // ------------------------------------------------------------
  // Peripheral inputs
  // ------------------------------------------------------------
  // Unselected serial lines idle high, the bus's released level
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_serial_bus_interface_in <= 3'h7;
      o_time_base_ext_clock_in  <= 1'b0;
      o_capture_trigger_in      <= 4'h0;
    end else begin
      o_serial_bus_interface_in <= pf_pin_s[2:0] | ~pf_fsel_reg[2:0];
      o_time_base_ext_clock_in  <= pf_pin_s[GPF_F_TBCLK] & pf_fsel_reg[GPF_F_TBCLK];
      o_capture_trigger_in      <= pg_pin_s[3:0] & pg_fsel_reg[3:0];
    end
  end

  // ------------------------------------------------------------
  // DMA sharing with the other port
  // ------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dma_request_ch2          <= 1'b0;
      o_dma_request_ch3          <= 1'b0;
      o_alt_port_dma_acknowledge <= 2'b00;
    end else begin
      o_dma_request_ch2 <= pf_fsel_reg[GPF_F_REQ2] ? pf_pin_s[GPF_F_REQ2]
                         : (i_alt_port_dma_sel[0] & i_alt_port_dma_request[0]);
      o_dma_request_ch3 <= pf_fsel_reg[GPF_F_REQ3] ? pf_pin_s[GPF_F_REQ3]
                         : (i_alt_port_dma_sel[1] & i_alt_port_dma_request[1]);
      o_alt_port_dma_acknowledge[0] <= i_dma_acknowledge_ch2 & i_alt_port_dma_sel[0]
                                       & ~pf_fsel_reg[GPF_F_ACK2];
      o_alt_port_dma_acknowledge[1] <= i_dma_acknowledge_ch3 & i_alt_port_dma_sel[1]
                                       & ~pf_fsel_reg[GPF_F_ACK3];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  logic first_reg;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_wr_dir;
    i_wr && i_addr == GPF_OFF_F_DIR;
  endsequence

  // Drive type taken one cycle back so a back-to-back write cannot skew it
  sequence s_drive_settles;
    ##2 o_pf_drv.oe == ($past(i_wr_data, 2) & ~($past(pf_drv_reg) & o_pf_drv.out));
  endsequence

  a_reset_first_port: assert property (first_reg |->
    pf_dir_reg == 8'h00 && pf_fsel_reg == 8'h00 && o_pf_drv.oe == 8'h00)
    else $error("first port not cleared by reset");

  a_reset_other_ports: assert property (first_reg |->
    pg_dir_reg == 8'h00 && pg_fsel_reg == 8'h00 && ph_dir_reg == 8'h00 && ph_fsel_reg == 8'h00)
    else $error("second or third port not cleared by reset");

  a_reset_latches: assert property (first_reg |->
    pf_latch_reg == 8'hff && pg_latch_reg == 8'hff && ph_latch_reg == 8'hff)
    else $error("data latch not all ones after reset");

  a_dir_drives_oe: assert property (s_wr_dir |->
    s_drive_settles)
    else $error("direction write did not reach pad enable");

  a_first_port_oe: assert property (##1 o_pf_drv.oe ==
    $past(pf_dir_reg & ~(pf_drv_reg & ((pf_fsel_reg & pf_alt) | (~pf_fsel_reg & pf_latch_reg)))))
    else $error("first port enable does not follow direction");

  a_alt_serial_out: assert property (pf_fsel_reg[0] |=>
    o_pf_drv.out[0] == $past(i_serial_bus_interface_out[0]))
    else $error("serial out not on pin 0");

  a_gpio_keeps_latch: assert property (!pf_fsel_reg[0] |=>
    o_pf_drv.out[0] == $past(pf_latch_reg[0]))
    else $error("gpio pin 0 lost its latch");

  a_serial_in: assert property (pf_fsel_reg[1] |=>
    o_serial_bus_interface_in[1] == $past(pf_pin_s[1]))
    else $error("serial in not taken from pin 1");

  a_dma_request: assert property (pf_fsel_reg[GPF_F_REQ2] |=>
    o_dma_request_ch2 == $past(pf_pin_s[GPF_F_REQ2]))
    else $error("channel 2 request not from first port");

  a_dma_ack: assert property (pf_fsel_reg[GPF_F_ACK3] |=>
    o_pf_drv.out[GPF_F_ACK3] == $past(i_dma_acknowledge_ch3))
    else $error("channel 3 acknowledge not on pin 6");

  a_tb_clock: assert property (##1 o_time_base_ext_clock_in ==
    $past(pf_fsel_reg[GPF_F_TBCLK] & pf_pin_s[GPF_F_TBCLK]))
    else $error("time base clock routing wrong");

  a_dma_priority: assert property (pf_fsel_reg[GPF_F_ACK2] && i_alt_port_dma_sel[0] |=>
    o_alt_port_dma_acknowledge[0] == 1'b0)
    else $error("other port acknowledged while first port owns dma");

  a_drive_type_bits: assert property (pf_drv_reg[7:2] == 6'h00)
    else $error("drive type upper bits set");

  a_capture_in: assert property (##1 o_capture_trigger_in ==
    $past(pg_pin_s[3:0] & pg_fsel_reg[3:0]))
    else $error("capture trigger routing wrong");

  a_g_compare_sel: assert property (pg_fsel_reg[GPF_G_CMP_LO] |=>
    o_pg_drv.out[GPF_G_CMP_LO] == $past(i_compare_out[0]))
    else $error("compare 0 not on second port pin 4");

  a_h_compare_out: assert property (ph_fsel_reg[GPF_H_CMP_NUM-1] |=>
    o_ph_drv.out[GPF_H_CMP_NUM-1] == $past(i_compare_out[9]))
    else $error("compare 9 not on third port pin 5");

  a_data_readback: assert property (i_rd && i_addr == GPF_OFF_G_DATA |=>
    o_rd_data == $past((pg_dir_reg & pg_latch_reg) | (~pg_dir_reg & pg_pin_s)))
    else $error("second port readback wrong");

  a_read_one_cycle: assert property (!i_rd |=> o_rd_data == 8'h00)
    else $error("read data outside read cycle");

endmodule : gpf_ports

// ### bench/gpf_pad_model.sv
`timescale 1ns/10ps
// ----------
// Pad wires with pull-ups
// ----------
module gpf_pad_model
  import gpf_pkg::*;
(
  // Module side
  input  wire gpf_pin_drv_s i_pf_drv,
  input  wire gpf_pin_drv_s i_pg_drv,
  input  wire gpf_pin_drv_s i_ph_drv,
  // Board side
  input  wire logic [23:0]  i_ext_val,
  input  wire logic [23:0]  i_ext_en,
  output logic      [23:0]  o_pin
);
  logic [23:0] oe;
  logic [23:0] val;
  assign oe  = {i_ph_drv.oe, i_pg_drv.oe, i_pf_drv.oe};
  assign val = {i_ph_drv.out, i_pg_drv.out, i_pf_drv.out};
  // Released pads float high; two drivers at once give an unknown level where the module drives low, high where it drives high
  assign o_pin = (oe & val) | (~oe & (~i_ext_en | i_ext_val)) | ({24{1'bx}} & oe & i_ext_en);
endmodule : gpf_pad_model

// ### bench/gpf_ports_tb_top.sv
`timescale 1ns/10ps
module gpf_ports_tb_top
  import gpf_pkg::*;
;
  // ----------
  // Signals and model state
  // ----------
  logic         i_sys_clk = 1'b0;
  logic         i_nrst = 1'b0;
  logic [7:0]   i_addr = 8'h00;
  logic [7:0]   i_wr_data = 8'h00;
  logic         i_wr = 1'b0;
  logic         i_rd = 1'b0;
  logic [7:0]   o_rd_data;
  logic [23:0]  pin;
  gpf_pin_drv_s drv [3];
  logic [2:0]   sbi_o = 3'h0;
  logic [2:0]   sbi_i;
  logic [1:0]   ack = 2'h0;
  logic [1:0]   a_sel = 2'h0;
  logic [1:0]   a_req = 2'h0;
  logic [1:0]   a_ack;
  logic         req2;
  logic         req3;
  logic [9:0]   cmpo = 10'h000;
  logic [3:0]   cap;
  logic         tbclk;
  logic [7:0]   ext_val [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]   ext_en [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]   m_lat [3];
  logic [7:0]   m_dir [3];
  logic [7:0]   m_fs [3];
  logic [7:0]   m_drv;
  int           failures = 0;
  int           tests_run = 0;
  logic [7:0]   offs [11] = '{GPF_OFF_F_DATA, GPF_OFF_G_DATA, GPF_OFF_H_DATA, GPF_OFF_F_DIR,
                              GPF_OFF_G_DIR, GPF_OFF_H_DIR, GPF_OFF_F_FSEL, GPF_OFF_G_FSEL,
                              GPF_OFF_H_FSEL, GPF_OFF_F_DRV, 8'h63};

  always #2.5 i_sys_clk = ~i_sys_clk;

  gpf_ports dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_pf_pin(pin[7:0]), .i_pg_pin(pin[15:8]), .i_ph_pin(pin[23:16]),
    .o_pf_drv(drv[0]), .o_pg_drv(drv[1]), .o_ph_drv(drv[2]),
    .i_serial_bus_interface_out(sbi_o), .o_serial_bus_interface_in(sbi_i),
    .i_dma_acknowledge_ch2(ack[0]), .i_dma_acknowledge_ch3(ack[1]),
    .i_alt_port_dma_sel(a_sel), .i_alt_port_dma_request(a_req),
    .o_dma_request_ch2(req2), .o_dma_request_ch3(req3), .o_alt_port_dma_acknowledge(a_ack),
    .i_compare_out(cmpo), .o_capture_trigger_in(cap), .o_time_base_ext_clock_in(tbclk));

  gpf_pad_model pads (.i_pf_drv(drv[0]), .i_pg_drv(drv[1]), .i_ph_drv(drv[2]),
    .i_ext_val({ext_val[2], ext_val[1], ext_val[0]}),
    .i_ext_en({ext_en[2], ext_en[1], ext_en[0]}), .o_pin(pin));

  // ----------
  // Reference model
  // ----------
  function automatic logic [7:0] per(int p);
    case (p)
      0: per = {1'b0, ack[1], 1'b0, ack[0], 1'b0, sbi_o};
      1: per = {cmpo[3:0], 4'h0};
      default: per = {2'b00, cmpo[9:4]};
    endcase
  endfunction : per

  function automatic logic [7:0] e_out(int p);
    e_out = (m_fs[p] & per(p)) | (~m_fs[p] & m_lat[p]);
  endfunction : e_out

  function automatic logic [7:0] e_oe(int p);
    e_oe = m_dir[p] & ~(((p == 0) ? m_drv : 8'h00) & e_out(p));
  endfunction : e_oe

  function automatic logic [7:0] e_pin(int p);
    e_pin = (e_oe(p) & e_out(p)) | (~e_oe(p) & (~ext_en[p] | ext_val[p]));
  endfunction : e_pin

  function automatic logic [7:0] mdl_rd(logic [7:0] a);
    mdl_rd = (a == GPF_OFF_F_DRV) ? m_drv : 8'h00;
    for (int p = 0; p < 3; p++) begin
      if (a == GPF_OFF_F_DATA + 8'(p)) mdl_rd = (m_dir[p] & m_lat[p]) | (~m_dir[p] & e_pin(p));
      if (a == GPF_OFF_F_DIR + 8'(p)) mdl_rd = m_dir[p];
      if (a == GPF_OFF_F_FSEL + 8'(p)) mdl_rd = m_fs[p];
    end
  endfunction : mdl_rd

  task automatic mdl_wr(logic [7:0] a, logic [7:0] d);
    for (int p = 0; p < 3; p++) begin
      if (a == GPF_OFF_F_DATA + 8'(p)) m_lat[p] = d;
      if (a == GPF_OFF_F_DIR + 8'(p)) m_dir[p] = d;
      if (a == GPF_OFF_F_FSEL + 8'(p)) m_fs[p] = (p == 2) ? (d & GPF_MSK_H_FSEL) : d;
    end
    if (a == GPF_OFF_F_DRV) m_drv = d & GPF_MSK_F_DRV;
  endtask : mdl_wr

  // ----------
  // Bus, compare and reset tasks
  // ----------
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic bus_wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    mdl_wr(a, d);
  endtask : bus_wr

  task automatic bus_rd(logic [7:0] a, output logic [7:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rd_data;
  endtask : bus_rd

  task automatic do_reset();
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (int p = 0; p < 3; p++) begin
      m_lat[p] = 8'hff;
      m_dir[p] = 8'h00;
      m_fs[p] = 8'h00;
    end
    m_drv = 8'h00;
  endtask : do_reset

  // Settle pads and sync stages, then compare every output and register
  task automatic check_all();
    logic [7:0] d;
    logic [7:0] km;
    logic [7:0] pf;
    logic [7:0] pg;
    repeat (6) @(posedge i_sys_clk);
    #1;
    pf = e_pin(0);
    pg = e_pin(1);
    for (int p = 0; p < 3; p++) begin
      // Out value of input-function pins is left open
      km = (p == 0) ? (~m_fs[0] | 8'h57) : ((p == 1) ? (~m_fs[1] | 8'hf0) : 8'hff);
      cmp($sformatf("drive %0d", p), {e_out(p) & km, e_oe(p)},
          {drv[p].out & km, drv[p].oe});
    end
    cmp("peripherals", {4'h0, m_fs[0][7] & pf[7], m_fs[1][3:0] & pg[3:0],
        ack[1] & a_sel[1] & ~m_fs[0][6], ack[0] & a_sel[0] & ~m_fs[0][4],
        m_fs[0][5] ? pf[5] : (a_sel[1] & a_req[1]), m_fs[0][3] ? pf[3] : (a_sel[0] & a_req[0]),
        (m_fs[0][2:0] & pf[2:0]) | ~m_fs[0][2:0]},
        {4'h0, tbclk, cap, a_ack, req3, req2, sbi_i});
    for (int i = 0; i < 11; i++) begin
      bus_rd(offs[i], d);
      cmp($sformatf("reg %h", offs[i]), {8'h00, mdl_rd(offs[i])},
          {8'h00, d});
    end
  endtask : check_all

  task automatic cfg(int i);
    logic [7:0] fs [3];
    logic [7:0] dr [3];
    @(posedge i_sys_clk);
    for (int p = 0; p < 3; p++) ext_en[p] <= 8'h00;
    for (int p = 0; p < 3; p++) fs[p] = i[0] ? 8'($urandom) : 8'h00;
    fs[0] = i[1] ? (fs[0] | 8'h78) : (fs[0] & 8'h87);
    // Input-function pins stay inputs so no two drivers meet
    dr[0] = 8'($urandom) & (~fs[0] | 8'h57);
    dr[1] = 8'($urandom) & (~fs[1] | 8'hf0);
    dr[2] = 8'($urandom);
    for (int p = 0; p < 3; p++) begin
      bus_wr(GPF_OFF_F_FSEL + 8'(p), fs[p]);
      bus_wr(GPF_OFF_F_DATA + 8'(p), 8'($urandom));
      bus_wr(GPF_OFF_F_DIR + 8'(p), dr[p]);
    end
    bus_wr(GPF_OFF_F_DRV, 8'($urandom));
    @(posedge i_sys_clk);
    for (int p = 0; p < 3; p++) ext_en[p] <= ~m_dir[p];
    for (int p = 0; p < 3; p++) ext_val[p] <= 8'($urandom);
    {sbi_o, ack, a_sel, a_req} <= 9'($urandom);
    cmpo <= 10'($urandom);
  endtask : cfg

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // ----------
  // Test sequence
  // ----------
  initial begin
    logic [7:0] d;
    logic [7:0] r;
    void'($urandom(72));
    do_reset();
    check_all();
    $display("Test reset values done");
    for (int i = 0; i < 11; i++) begin
      d = 8'($urandom);
      bus_wr(offs[i], d);
      bus_rd(offs[i], r);
      cmp($sformatf("rw %h", offs[i]), {8'h00, mdl_rd(offs[i])}, {8'h00, r});
    end
    $display("Test register access done");
    for (int i = 0; i < 10; i++) begin
      cfg(i);
      check_all();
    end
    $display("Test pin functions done");
    do_reset();
    check_all();
    $display("Test second reset done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    tally_and_finish();
  end
endmodule : gpf_ports_tb_top
